/* logic/usmspi_top.v */
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "usmspi_regs.vh"
module usmspi_top #(
  parameter BAUD_W = `USM_BAUD_W
) (
  input wire sys_clk,
  input wire rstn,
  input wire [`USM_ADDR_W-1:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [7:0] bus_rdata_q,
  input wire global_irq_en,
  input wire tx_done_irq_ack,
  input wire serial_in_pin,
  output wire serial_clock_pin_q,
  output reg serial_clock_oe_q,
  output wire serial_out_pin_q,
  output reg serial_out_oe_q,
  output reg serial_in_owned_q,
  output reg irq_rx_done_q,
  output reg irq_tx_done_q,
  output reg irq_tx_empty_q
);
  reg [7:0] ctrl_b_q;
  reg [7:0] ctrl_c_q;
  reg [BAUD_W-1:0] baud_divisor_q;
  reg [7:0] tx_buf_q;
  reg tx_full_q;
  reg tx_done_flag_q;
  reg [7:0] rx_mem [0:1];
  reg rx_rd_ptr_q;
  reg rx_wr_ptr_q;
  reg [1:0] rx_cnt_q;
  reg in_meta_q;
  reg in_sync_q;
  reg [7:0] rdata_d;

  wire eng_busy;
  wire eng_done;
  wire [7:0] eng_rx;
  wire master_spi_mode;
  wire transmitter_enable;
  wire receiver_enable;
  wire rx_done_flag;
  wire tx_buf_empty_flag;
  wire launch;
  wire data_wr;
  wire data_rd;
  wire stat_wr;
  wire rx_push;
  wire rx_pop;

  function hit;
    input [`USM_ADDR_W-1:0] addr;
    input [`USM_ADDR_W-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign master_spi_mode = ({ctrl_c_q[`USM_MODE_HI], ctrl_c_q[`USM_MODE_LO]} == `USM_MODE_MSPI);
  assign transmitter_enable = ctrl_b_q[`USM_TX_EN_BIT];
  assign receiver_enable = ctrl_b_q[`USM_RX_EN_BIT];
  assign rx_done_flag = (rx_cnt_q != 2'h0);
  assign tx_buf_empty_flag = ~tx_full_q;
  assign data_wr = bus_wr & hit(bus_addr, `USM_OFS_DATA);
  assign data_rd = bus_rd & hit(bus_addr, `USM_OFS_DATA);
  assign stat_wr = bus_wr & hit(bus_addr, `USM_OFS_STAT_A);
  assign launch = tx_full_q & ~eng_busy & master_spi_mode;
  assign rx_pop = data_rd & rx_done_flag;
  assign rx_push = eng_done & receiver_enable & master_spi_mode & (rx_cnt_q != 2'h2 | rx_pop);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      in_meta_q <= 1'b1;
      in_sync_q <= 1'b1;
    end else begin
      in_meta_q <= serial_in_pin;
      in_sync_q <= in_meta_q;
    end
  end

  usmspi_shift #(
    .BAUD_W(BAUD_W)
  ) u_shift (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(launch),
    .tx_byte(tx_buf_q),
    .lsb_first(ctrl_c_q[`USM_ORDER_BIT]),
    .cpha(ctrl_c_q[`USM_PHASE_BIT]),
    .cpol(ctrl_c_q[`USM_POL_BIT]),
    .divisor(baud_divisor_q),
    .miso(in_sync_q),
    .sck_q(serial_clock_pin_q),
    .mosi_q(serial_out_pin_q),
    .busy_q(eng_busy),
    .done_q(eng_done),
    .rx_byte_q(eng_rx)
  );

  // control registers
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_b_q <= `USM_CTRL_B_RST;
      ctrl_c_q <= `USM_CTRL_C_RST;
      baud_divisor_q <= `USM_BAUD_RST;
    end else if (bus_wr) begin
      if (hit(bus_addr, `USM_OFS_CTRL_B)) begin
        ctrl_b_q <= {bus_wdata[7:3], 3'h0};
      end
      if (hit(bus_addr, `USM_OFS_CTRL_C)) begin
        ctrl_c_q <= {bus_wdata[7:6], 3'h0, bus_wdata[2:0]};
      end
      if (hit(bus_addr, `USM_OFS_BAUD_L)) begin
        baud_divisor_q[7:0] <= bus_wdata;
      end
      if (hit(bus_addr, `USM_OFS_BAUD_H)) begin
        baud_divisor_q[BAUD_W-1:8] <= bus_wdata[BAUD_W-9:0];
      end
    end
  end

  // transmit holding buffer ahead of the shift engine
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buf_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else begin
      if (launch) begin
        tx_full_q <= 1'b0;
      end else if (data_wr & tx_buf_empty_flag & transmitter_enable & master_spi_mode) begin
        tx_buf_q <= bus_wdata;
        tx_full_q <= 1'b1;
      end
    end
  end

  // transmit complete flag
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_done_flag_q <= 1'b0;
    end else begin
      if (eng_done & ~tx_full_q) begin
        tx_done_flag_q <= 1'b1;
      end else if (tx_done_irq_ack | (stat_wr & bus_wdata[`USM_TX_DONE_BIT])) begin
        tx_done_flag_q <= 1'b0;
      end
    end
  end

  // two-level receive buffer
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_rd_ptr_q <= 1'b0;
      rx_wr_ptr_q <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else if (!receiver_enable) begin
      rx_rd_ptr_q <= 1'b0;
      rx_wr_ptr_q <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else begin
      if (rx_push) begin
        rx_wr_ptr_q <= ~rx_wr_ptr_q;
      end
      if (rx_pop) begin
        rx_rd_ptr_q <= ~rx_rd_ptr_q;
      end
      if (rx_push & ~rx_pop) begin
        rx_cnt_q <= rx_cnt_q + 2'h1;
      end else if (rx_pop & ~rx_push) begin
        rx_cnt_q <= rx_cnt_q - 2'h1;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_ptr_q] <= eng_rx;
    end
  end

  // register read mux
  always @* begin
    rdata_d = 8'h00;
    case (bus_addr)
      `USM_OFS_DATA: begin
        if (rx_done_flag) begin
          rdata_d = rx_mem[rx_rd_ptr_q];
        end
      end
      `USM_OFS_STAT_A: begin
        rdata_d = {rx_done_flag, tx_done_flag_q, tx_buf_empty_flag, 5'h00};
      end
      `USM_OFS_CTRL_B: begin
        rdata_d = ctrl_b_q;
      end
      `USM_OFS_CTRL_C: begin
        rdata_d = ctrl_c_q;
      end
      `USM_OFS_BAUD_L: begin
        rdata_d = baud_divisor_q[7:0];
      end
      `USM_OFS_BAUD_H: begin
        rdata_d = {{(16-BAUD_W){1'b0}}, baud_divisor_q[BAUD_W-1:8]};
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata_q <= rdata_d;
    end else begin
      bus_rdata_q <= 8'h00;
    end
  end

  // pin ownership and interrupt requests
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serial_out_oe_q <= 1'b0;
      serial_clock_oe_q <= 1'b0;
      serial_in_owned_q <= 1'b0;
      irq_rx_done_q <= 1'b0;
      irq_tx_done_q <= 1'b0;
      irq_tx_empty_q <= 1'b0;
    end else begin
      serial_out_oe_q <= master_spi_mode & (transmitter_enable | eng_busy | tx_full_q);
      serial_clock_oe_q <= master_spi_mode & (transmitter_enable | eng_busy | tx_full_q);
      serial_in_owned_q <= master_spi_mode & receiver_enable;
      irq_rx_done_q <= ctrl_b_q[`USM_RX_IRQ_EN_BIT] & global_irq_en & rx_done_flag;
      irq_tx_done_q <= ctrl_b_q[`USM_TX_IRQ_EN_BIT] & global_irq_en & tx_done_flag_q;
      irq_tx_empty_q <= ctrl_b_q[`USM_EMPTY_IRQ_EN_BIT] & global_irq_en & tx_buf_empty_flag;
    end
  end
endmodule // usmspi_top

/* logic/usmspi_regs.vh */
`ifndef USMSPI_REGS_VH
`define USMSPI_REGS_VH
// register offsets on the plain register port
`define USM_ADDR_W 3
`define USM_OFS_DATA 3'h0
`define USM_OFS_STAT_A 3'h1
`define USM_OFS_CTRL_B 3'h2
`define USM_OFS_CTRL_C 3'h3
`define USM_OFS_BAUD_L 3'h4
`define USM_OFS_BAUD_H 3'h5
// serial_spi_status_a fields
`define USM_RX_DONE_BIT 7
`define USM_TX_DONE_BIT 6
`define USM_TX_EMPTY_BIT 5
// serial_spi_control_b fields
`define USM_RX_IRQ_EN_BIT 7
`define USM_TX_IRQ_EN_BIT 6
`define USM_EMPTY_IRQ_EN_BIT 5
`define USM_RX_EN_BIT 4
`define USM_TX_EN_BIT 3
// serial_spi_control_c fields
`define USM_MODE_HI 7
`define USM_MODE_LO 6
`define USM_ORDER_BIT 2
`define USM_PHASE_BIT 1
`define USM_POL_BIT 0
// op_mode_select codes
`define USM_MODE_ASYNC 2'h0
`define USM_MODE_SYNC 2'h1
`define USM_MODE_RSVD 2'h2
`define USM_MODE_MSPI 2'h3
// reset values
`define USM_CTRL_B_RST 8'h00
`define USM_CTRL_C_RST 8'h00
`define USM_BAUD_RST 12'h000
// frame timing
`define USM_BAUD_W 12
`define USM_LAST_EDGE 4'hF
`endif

/* logic/usmspi_shift.v */
`timescale 1ns/1ps
`include "usmspi_regs.vh"
module usmspi_shift #(
  parameter BAUD_W = 12
) (
  input wire sys_clk,
  input wire rstn,
  input wire start,
  input wire [7:0] tx_byte,
  input wire lsb_first,
  input wire cpha,
  input wire cpol,
  input wire [BAUD_W-1:0] divisor,
  input wire miso,
  output reg sck_q,
  output reg mosi_q,
  output reg busy_q,
  output reg done_q,
  output reg [7:0] rx_byte_q
);
  reg [7:0] tx_sh_q;
  reg [3:0] edge_q;
  reg [BAUD_W-1:0] cnt_q;

  function first_bit;
    input [7:0] sh;
    input lsb;
    begin
      first_bit = lsb ? sh[0] : sh[7];
    end
  endfunction

  function [7:0] shift_on;
    input [7:0] sh;
    input lsb;
    input din;
    begin
      shift_on = lsb ? {din, sh[7:1]} : {sh[6:0], din};
    end
  endfunction

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b0;
      mosi_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rx_byte_q <= 8'h00;
      tx_sh_q <= 8'h00;
      edge_q <= 4'h0;
      cnt_q <= {BAUD_W{1'b0}};
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        sck_q <= cpol;
        edge_q <= 4'h0;
        cnt_q <= {BAUD_W{1'b0}};
        if (start) begin
          busy_q <= 1'b1;
          if (!cpha) begin
            mosi_q <= first_bit(tx_byte, lsb_first);
            tx_sh_q <= shift_on(tx_byte, lsb_first, 1'b0);
          end else begin
            tx_sh_q <= tx_byte;
          end
        end
      end else if (cnt_q == divisor) begin
        cnt_q <= {BAUD_W{1'b0}};
        sck_q <= ~sck_q;
        edge_q <= edge_q + 4'h1;
        if (!edge_q[0]) begin
          if (cpha) begin
            mosi_q <= first_bit(tx_sh_q, lsb_first);
            tx_sh_q <= shift_on(tx_sh_q, lsb_first, 1'b0);
          end else begin
            rx_byte_q <= shift_on(rx_byte_q, lsb_first, miso);
          end
        end else begin
          if (cpha) begin
            rx_byte_q <= shift_on(rx_byte_q, lsb_first, miso);
          end else if (edge_q != `USM_LAST_EDGE) begin
            mosi_q <= first_bit(tx_sh_q, lsb_first);
            tx_sh_q <= shift_on(tx_sh_q, lsb_first, 1'b0);
          end
        end
        if (edge_q == `USM_LAST_EDGE) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q + {{(BAUD_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // usmspi_shift

/* sim/usmspi_checker.sv */
`timescale 1ns/1ps
module usmspi_checker (
  input wire sys_clk,
  input wire rstn,
  input wire [2:0] bus_addr,
  input wire [7:0] bus_wdata,
  input wire bus_wr,
  input wire global_irq_en,
  input wire serial_clock_pin_q,
  input wire serial_out_oe_q,
  input wire serial_in_owned_q,
  input wire irq_rx_done_q,
  input wire irq_tx_done_q,
  input wire irq_tx_empty_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  reg [11:0] div_q;
  reg [11:0] hcnt_q;
  reg sck_q;
  reg txen_q;
  reg spi_q;
  wire ctl_b = bus_wr && bus_addr == 3'h2;
  wire sck_edge = serial_clock_pin_q != sck_q;
  // mirrors divisor and enable, counts cycles since the last clock edge
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 12'h000;
      hcnt_q <= 12'hFFF;
      sck_q <= 1'b0;
      txen_q <= 1'b0;
      spi_q <= 1'b0;
    end else begin
      sck_q <= serial_clock_pin_q;
      hcnt_q <= sck_edge ? 12'h000 : hcnt_q + {11'h000, hcnt_q != 12'hFFF};
      if (bus_wr && bus_addr == 3'h4) div_q[7:0] <= bus_wdata;
      if (bus_wr && bus_addr == 3'h5) div_q[11:8] <= bus_wdata[3:0];
      if (ctl_b) txen_q <= bus_wdata[3];
      // pins are only taken while the mode field selects master spi
      if (bus_wr && bus_addr == 3'h3) spi_q <= (bus_wdata[7:6] == 2'h3);
    end
  end
  a_rx_irq_gate: assert property (irq_rx_done_q |-> $past(global_irq_en))
    else $error("rx request without global enable");
  a_txc_irq_gate: assert property (irq_tx_done_q |-> $past(global_irq_en))
    else $error("tx done request without global enable");
  a_txe_irq_gate: assert property (irq_tx_empty_q |-> $past(global_irq_en))
    else $error("tx empty request without global enable");
  a_rx_pin_take: assert property (ctl_b && spi_q && bus_wdata[4] |-> ##[1:2] serial_in_owned_q)
    else $error("input pin not taken");
  a_rx_flush_now: assert property (ctl_b && !bus_wdata[4] |-> ##[1:3] !irq_rx_done_q && !serial_in_owned_q)
    else $error("receive side not flushed");
  a_tx_pin_take: assert property (ctl_b && spi_q && bus_wdata[3] |-> ##[1:2] serial_out_oe_q)
    else $error("output pin not taken");
  a_tx_pin_keep: assert property ($fell(serial_out_oe_q) |-> !txen_q)
    else $error("output pin released while enabled");
  a_sck_half_period: assert property (sck_edge |-> hcnt_q >= div_q)
    else $error("serial clock half period too short");
  c_spi_edge: cover property (sck_edge && div_q != 12'h000);
  c_txc_req: cover property (irq_tx_done_q);
  c_tx_drain: cover property ($fell(serial_out_oe_q));
endmodule // usmspi_checker

/* sim/usmspi_slave.sv */
`timescale 1ns/1ps
module usmspi_slave #(
  parameter [7:0] INIT = 8'h35
) (
  input wire sck,
  input wire mosi,
  input wire cpol,
  input wire cpha,
  input wire lsb,
  input wire rstn,
  output reg miso,
  output reg [7:0] got,
  output reg [7:0] frames
);
  reg prev;
  reg [7:0] sh;
  integer n;
  // echo slave: each frame returns the byte taken in the frame before
  always @(sck or rstn) begin
    if (!rstn) begin
      prev = sck;
      n = 0;
      frames = 8'h00;
      got = INIT;
      miso = INIT[lsb ? 0 : 7];
    end else if (sck != prev) begin
      prev = sck;
      if ((sck != cpol) != cpha) begin
        sh[lsb ? n : 7 - n] = mosi;
        n = n + 1;
        if (n == 8) begin
          got = sh;
          frames = frames + 8'h01;
          n = 0;
        end
      end else begin
        miso = got[lsb ? n : 7 - n];
      end
    end
  end
endmodule // usmspi_slave

/* sim/usmspi_top_bench.sv */
`timescale 1ns/1ps
module usmspi_top_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sl_rstn = 1'b1;
  logic [2:0] a = 3'h0;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gie = 1'b0;
  logic ack = 1'b0;
  logic [2:0] cfg = 3'h0;
  logic [7:0] d;
  wire [7:0] rdata, got, frames;
  wire miso, sck, mosi, oe, coe, own, i_rx, i_txc, i_txe;
  int bad_count = 0;
  int samples_checked = 0;
  int i;
  usmspi_top uut (.sys_clk(clk), .rstn(rstn), .bus_addr(a), .bus_wdata(wd), .bus_wr(wr), .bus_rd(rd),
    .bus_rdata_q(rdata), .global_irq_en(gie), .tx_done_irq_ack(ack), .serial_in_pin(miso),
    .serial_clock_pin_q(sck), .serial_clock_oe_q(coe), .serial_out_pin_q(mosi), .serial_out_oe_q(oe),
    .serial_in_owned_q(own), .irq_rx_done_q(i_rx), .irq_tx_done_q(i_txc), .irq_tx_empty_q(i_txe));
  usmspi_slave sl (.sck(sck), .mosi(mosi), .cpol(cfg[0]), .cpha(cfg[1]), .lsb(cfg[2]), .rstn(sl_rstn),
    .miso(miso), .got(got), .frames(frames));
  initial forever #5 clk = ~clk;
  initial begin
    #300000;
    bad_count++;
    results;
  end
  task results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task rd_reg(input logic [2:0] ad, output logic [7:0] v);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task rd_chk(input logic [2:0] ad, input logic [7:0] e);
    logic [7:0] v;
    rd_reg(ad, v);
    chk(v, e);
  endtask
  task wr_reg(input logic [2:0] ad, input logic [7:0] v);
    @(posedge clk);
    a <= ad;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task wait_st(input int b);
    logic [7:0] v;
    int n;
    v = 8'h00;
    for (n = 0; n < 300 && v[b] !== 1'b1; n++) rd_reg(3'h1, v);
    chk({7'h0, v[b]}, 8'h01);
  endtask
  task rst_all;
    @(posedge clk) rstn <= 1'b0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task spi_on(input logic [2:0] c);
    cfg <= c;
    wr_reg(3'h3, {5'h18, c});
    wr_reg(3'h2, 8'h18);
    wr_reg(3'h4, 8'h05);
    sl_rstn <= 1'b0;
    @(posedge clk) sl_rstn <= 1'b1;
  endtask
  initial begin
    rst_all;
    rd_chk(3'h1, 8'h20);
    rd_chk(3'h2, 8'h00);
    rd_chk(3'h3, 8'h00);
    wr_reg(3'h6, 8'hFF);
    rd_chk(3'h6, 8'h00);
    $display("test reset values done");
    wr_reg(3'h2, 8'h18);
    for (i = 0; i < 3; i++) begin
      wr_reg(3'h3, {i[1:0], 6'h00});
      wr_reg(3'h0, 8'h5A);
      repeat (120) @(posedge clk);
      rd_chk(3'h1, 8'h20);
    end
    $display("test other modes done");
    for (i = 0; i < 8; i++) begin
      rst_all;
      spi_on(i[2:0]);
      d = 8'h1D ^ {i[2:0], 5'h00};
      wr_reg(3'h0, d);
      wait_st(7);
      rd_chk(3'h1, 8'hE0);
      rd_chk(3'h0, 8'h35);
      rd_chk(3'h1, 8'h60);
      chk(got, d);
      chk({7'h0, sck}, {7'h0, i[0]});
    end
    $display("test spi modes done");
    rst_all;
    spi_on(3'h0);
    wr_reg(3'h0, 8'hC1);
    wr_reg(3'h0, 8'h52);
    rd_chk(3'h1, 8'h00);
    wait_st(5);
    wr_reg(3'h0, 8'h0F);
    wait_st(6);
    chk(frames, 8'h03);
    rd_chk(3'h0, 8'h35);
    rd_chk(3'h0, 8'hC1);
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h1, 8'h60);
    $display("test back to back done");
    @(posedge clk) gie <= 1'b1;
    wr_reg(3'h2, 8'hF8);
    repeat (2) @(posedge clk);
    #1 chk({4'h0, own, i_rx, i_txc, i_txe}, 8'h0B);
    @(posedge clk) ack <= 1'b1;
    @(posedge clk) ack <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({7'h0, i_txc}, 8'h00);
    wr_reg(3'h0, 8'h99);
    wait_st(7);
    chk({7'h0, i_rx}, 8'h01);
    wr_reg(3'h1, 8'h40);
    rd_chk(3'h1, 8'hA0);
    @(posedge clk) gie <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({5'h0, i_rx, i_txc, i_txe}, 8'h00);
    wr_reg(3'h2, 8'h08);
    rd_chk(3'h1, 8'h20);
    chk({7'h0, own}, 8'h00);
    $display("test interrupts done");
    wr_reg(3'h0, 8'h11);
    wr_reg(3'h0, 8'h22);
    wr_reg(3'h2, 8'h00);
    #1 chk({6'h0, coe, oe}, 8'h03);
    wait_st(6);
    repeat (4) @(posedge clk);
    #1 chk({6'h0, coe, oe}, 8'h00);
    chk(frames, 8'h06);
    $display("test disable done");
    results;
  end
endmodule // usmspi_top_bench
bind usmspi_top usmspi_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .global_irq_en(global_irq_en),
  .serial_clock_pin_q(serial_clock_pin_q), .serial_out_oe_q(serial_out_oe_q),
  .serial_in_owned_q(serial_in_owned_q), .irq_rx_done_q(irq_rx_done_q),
  .irq_tx_done_q(irq_tx_done_q), .irq_tx_empty_q(irq_tx_empty_q));
